// ===== dv/tas_rx_model.sv
// receiver model: learns key and address, then checks tags and counter freshness
`default_nettype none
module tas_rx_model (
  input wire logic clk, // bench clock
  input wire logic arst_n, // async reset, active low
  input wire logic tel_valid, // telegram strobe
  input wire tas_pkg::tas_tel_t tel, // telegram on air
  output logic auth_ok, // tag of last data telegram matched
  output logic fresh // counter of last data telegram was new
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] key = '0;
  logic [47:0] addr = '0;
  logic [31:0] last = '0;
  logic seen = 1'b0;
  logic good;
  logic [31:0] ctr;
  logic [31:0] sig;
  assign ctr = {tel.bytes[183:176], tel.bytes[191:184], tel.bytes[199:192], tel.bytes[207:200]};
  assign sig = 32'(tel.bytes >> (8 * (30 - int'(tel.count))));
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      p = b[i] ? p ^ a : p;
      a = xt(a);
    end
    return p;
  endfunction
  // slow on purpose: inverse as power 254 keeps the model free of tables
  function automatic logic [7:0] sb(input logic [7:0] a);
    logic [7:0] v;
    v = a;
    for (int i = 0; i < 253; i++)
      v = gm(v, a);
    return v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]} ^ {v[3:0], v[7:4]} ^ 8'h63;
  endfunction
  function automatic logic [127:0] aes(input logic [127:0] k, input logic [127:0] p);
    logic [7:0] s [16];
    logic [7:0] t [16];
    logic [7:0] w [16];
    logic [7:0] rc;
    logic [127:0] o;
    int a1;
    rc = 8'h01;
    for (int i = 0; i < 16; i++)
    begin
      w[i] = k[127 - 8 * i -: 8];
      s[i] = p[127 - 8 * i -: 8] ^ w[i];
    end
    for (int r = 1; r <= 10; r++)
    begin
      t[0] = sb(w[13]) ^ rc;
      t[1] = sb(w[14]);
      t[2] = sb(w[15]);
      t[3] = sb(w[12]);
      for (int i = 0; i < 4; i++)
        w[i] = w[i] ^ t[i];
      for (int i = 4; i < 16; i++)
        w[i] = w[i] ^ w[i - 4];
      rc = xt(rc);
      for (int i = 0; i < 16; i++)
        t[i] = sb(s[(i + 4 * (i % 4)) % 16]);
      for (int i = 0; i < 16; i++)
      begin
        a1 = (i & 12) | ((i + 1) & 3);
        s[i] = xt(t[i]) ^ xt(t[a1]) ^ t[a1] ^ t[(i & 12) | ((i + 2) & 3)] ^ t[(i & 12) | ((i + 3) & 3)];
        s[i] = ((r == 10) ? t[i] : s[i]) ^ w[i];
      end
    end
    for (int i = 0; i < 16; i++)
      o[127 - 8 * i -: 8] = s[i];
    return o;
  endfunction
  function automatic logic [31:0] tag(input tas_pkg::tas_tel_t t, input logic [127:0] k, input logic [47:0] ad);
    logic [103:0] nonce;
    logic [255:0] a;
    logic [127:0] x;
    logic [127:0] s0;
    int n;
    n = int'(t.count) - 4;
    nonce = {ad, t.bytes[207:176], 24'h000000};
    a = {16'(n), t.bytes} & ({256{1'b1}} << (8 * (30 - n)));
    x = aes(k, {8'h49, nonce, 16'h0000});
    x = aes(k, x ^ a[255:128]);
    if (n > 14)
      x = aes(k, x ^ a[127:0]);
    s0 = aes(k, {8'h01, nonce, 16'h0000});
    return x[127:96] ^ s0[127:96];
  endfunction
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      auth_ok <= 1'b0;
      fresh <= 1'b0;
    end
    else if (tel_valid && tel.bytes[239:232] == 8'h1D)
    begin
      key <= tel.bytes[175:48];
      addr <= tel.bytes[47:0];
      last <= ctr;
      seen <= 1'b1;
    end
    else if (tel_valid)
    begin
      good = tag(tel, key, addr) == sig;
      auth_ok <= good;
      fresh <= !seen || ctr > last;
      if (good && (!seen || ctr > last))
      begin
        last <= ctr;
        seen <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the telegram signer with a receiver model
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("mismatch %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] ADDR = 48'hA1B2C3D4E5F6;
  localparam logic [127:0] FKEY = 128'h2B7E151628AED2A6ABF7158809CF4F3C;
  localparam logic [127:0] KEY2 = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [15:0] MAKER = 16'h5A71; // arbitrary value
  localparam logic [31:0] OD = 32'h44332211;
  logic clk = 1'b0;
  logic arst_n;
  logic req_valid;
  tas_pkg::tas_req_t req;
  logic cfg_wr;
  tas_pkg::tas_cfg_t cfg_in;
  logic factory_reset;
  logic key_wr;
  logic [127:0] key_in;
  logic key_rd;
  logic busy;
  logic tel_valid;
  tas_pkg::tas_tel_t tel;
  logic key_rd_valid;
  logic [127:0] key_rd_data;
  logic key_rd_refused;
  tas_pkg::tas_cfg_t cfg_out;
  logic [31:0] counter;
  logic auth_ok;
  logic fresh;
  logic [31:0] exp_ctr = '0;
  int n_fail = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  tas_signer #(.SRC_ADDR(ADDR), .FACTORY_KEY(FKEY), .MAKER_CODE(MAKER)) tas_signer_i (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req(req), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .factory_reset(factory_reset),
    .key_wr(key_wr), .key_in(key_in), .key_rd(key_rd), .busy(busy), .tel_valid(tel_valid), .tel(tel),
    .key_rd_valid(key_rd_valid), .key_rd_data(key_rd_data), .key_rd_refused(key_rd_refused),
    .cfg_out(cfg_out), .counter(counter));
  tas_rx_model tas_rx_model_i (.clk(clk), .arst_n(arst_n), .tel_valid(tel_valid), .tel(tel), .auth_ok(auth_ok),
    .fresh(fresh));
  function automatic logic [31:0] rev4(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic poke(input int which, input logic [127:0] v);
    @(posedge clk);
    #1 cfg_wr = (which == 0);
    key_wr = (which == 1);
    factory_reset = (which == 2);
    cfg_in = v[1:0];
    key_in = v;
    @(posedge clk);
    #1 {cfg_wr, key_wr, factory_reset} = 3'b000;
  endtask
  // a second request at drop_at cycles into the wait must be ignored while busy
  task automatic send(input logic com, input logic [7:0] sw, input logic [1:0] osz, input int drop_at,
    output int lat, output logic bz);
    @(posedge clk);
    #1 req_valid = 1'b1;
    req = '{com, sw, osz, OD};
    @(posedge clk);
    #1 req_valid = 1'b0;
    // lat counts up to the edge that drives tel_valid high
    lat = 1;
    bz = 1'b1;
    while (tel_valid !== 1'b1 && lat < 60)
    begin
      @(posedge clk);
      #1 lat++;
      req_valid = (lat == drop_at);
      if (tel_valid !== 1'b1 && busy !== 1'b1)
        bz = 1'b0;
    end
  endtask
  task automatic t_reset();
    `CHK("counter", 32'h0, counter)
    `CHK("cfg", 2'b00, cfg_out)
    `CHK("idle", 3'b000, {busy, tel_valid, key_rd_valid})
  endtask
  task automatic t_comm(input logic [127:0] k);
    int lat;
    logic bz;
    send(1'b1, 8'h00, 2'd0, -1, lat, bz);
    `CHK("comm latency", 1, lat)
    `CHK("comm count", 5'd30, tel.count)
    `CHK("comm payload", {8'h1D, 8'hFF, MAKER[7:0], MAKER[15:8], rev4(exp_ctr), k, ADDR[7:0], ADDR[15:8],
      ADDR[23:16], ADDR[31:24], ADDR[39:32], ADDR[47:40]}, tel.bytes)
    exp_ctr++;
    `CHK("comm counter", exp_ctr, counter)
    @(posedge clk);
    #1;
  endtask
  task automatic t_data(input logic [1:0] osz, input int drop_at);
    int nopt;
    int lat;
    logic bz;
    logic [7:0] len;
    logic [239:0] m;
    logic [239:0] e;
    nopt = (osz == 2'd3) ? 4 : int'(osz);
    len = (osz == 2'd3) ? 8'h10 : 8'h0C + 8'(osz);
    e = {len, 8'hFF, MAKER[7:0], MAKER[15:8], rev4(exp_ctr), 8'hA0 | 8'(osz), rev4(OD), 136'h0};
    send(1'b0, 8'hA0 | 8'(osz), osz, drop_at, lat, bz);
    exp_ctr++;
    `CHK("latency", 31, lat)
    `CHK("busy", 1'b1, bz)
    `CHK("count", 5'(13 + nopt), tel.count)
    m = {240{1'b1}} << (8 * (21 - nopt));
    `CHK("payload", e & m, tel.bytes & m)
    m = {240{1'b1}} << (8 * (17 - nopt));
    `CHK("tail", 240'h0, tel.bytes & ~m)
    `CHK("counter", exp_ctr, counter)
    @(posedge clk);
    #1;
    `CHK("auth", 1'b1, auth_ok)
    `CHK("fresh", 1'b1, fresh)
  endtask
  task automatic t_keyrd(input logic refused, input logic [127:0] k);
    @(posedge clk);
    #1 key_rd = 1'b1;
    @(posedge clk);
    #1 key_rd = 1'b0;
    `CHK("rd valid", 1'b1, key_rd_valid)
    `CHK("rd refused", refused, key_rd_refused)
    `CHK("rd data", k, key_rd_data)
  endtask
  task automatic t_newkey();
    poke(1, KEY2);
    t_keyrd(1'b0, KEY2);
    t_comm(KEY2);
    t_data(2'd3, -1);
  endtask
  task automatic t_private();
    poke(0, 128'h2);
    t_keyrd(1'b1, 128'h0);
  endtask
  task automatic t_comm_off();
    int lat;
    logic bz;
    poke(0, 128'h3);
    `CHK("cfg", 2'b11, cfg_out)
    send(1'b1, 8'h00, 2'd0, -1, lat, bz);
    `CHK("no telegram", 1'b0, tel_valid)
    `CHK("counter held", exp_ctr, counter)
  endtask
  task automatic t_factory();
    poke(2, 128'h0);
    `CHK("cfg cleared", 2'b00, cfg_out)
    t_keyrd(1'b0, FKEY);
    t_comm(FKEY);
    t_data(2'd2, -1);
  endtask
  initial
  begin
    {req_valid, cfg_wr, factory_reset, key_wr, key_rd} = 5'b00000;
    req = '0;
    cfg_in = '0;
    key_in = '0;
    arst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    t_reset();
    t_comm(FKEY);
    for (int i = 0; i < 4; i++)
      t_data(2'(i), (i == 1) ? 5 : -1);
    t_keyrd(1'b0, FKEY);
    t_newkey();
    t_private();
    t_comm_off();
    t_factory();
    give_verdict();
  end
  // the run needs about 300 cycles; 5000 leaves room without hiding a hang
  initial
  begin
    #20000;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== hw/tas_pkg.sv
// shared constants and carrier types for the telegram auth signer
`default_nettype none
package tas_pkg;
  // ----------------------------------------------------------------
  // payload field values
  // ----------------------------------------------------------------
  localparam logic [7:0] TAS_KIND_MFR = 8'hFF;
  localparam logic [7:0] TAS_LEN_COMM = 8'h1D;
  localparam logic [7:0] TAS_LEN_OPT0 = 8'h0C;
  localparam logic [7:0] TAS_LEN_OPT1 = 8'h0D;
  localparam logic [7:0] TAS_LEN_OPT2 = 8'h0E;
  localparam logic [7:0] TAS_LEN_OPT4 = 8'h10;
  localparam logic [4:0] TAS_COMM_BYTES = 5'h1E;
  localparam logic [4:0] TAS_SIG_BYTES = 5'h04;
  localparam logic [4:0] TAS_LEN_TO_COUNT = 5'h01;
  localparam logic [7:0] TAS_LEN_TO_AAD = 8'h03;
  // ----------------------------------------------------------------
  // ccm and aes constants
  // ----------------------------------------------------------------
  localparam logic [7:0] TAS_CCM_B0_FLAGS = 8'h49;
  localparam logic [7:0] TAS_CCM_A0_FLAGS = 8'h01;
  localparam logic [23:0] TAS_NONCE_PAD = 24'h000000;
  localparam logic [15:0] TAS_CCM_CTR0 = 16'h0000;
  localparam logic [7:0] TAS_AES_POLY = 8'h1B;
  localparam logic [7:0] TAS_SBOX_AFFINE = 8'h63;
  localparam logic [7:0] TAS_RCON_FIRST = 8'h01;
  localparam logic [3:0] TAS_AES_ROUNDS = 4'hA;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic commission;
    logic [7:0] switch_status;
    logic [1:0] opt_size;
    logic [31:0] opt_data;
  } tas_req_t;
  typedef struct packed {
    logic key_private;
    logic radio_commissioning_off;
  } tas_cfg_t;
  typedef struct packed {
    logic [4:0] count;
    logic [239:0] bytes;
  } tas_tel_t;
  typedef enum logic [0:0] {TAS_IDLE, TAS_CRYPT} tas_state_t;
endpackage
`default_nettype wire

// ===== hw/tas_signer.sv
// telegram payload builder and ccm signer of a pushbutton transmitter
// ------------------------------------------------------------------
// What this block does
// - static address also inside commissioning payload
// - commissioning order: 1D FF maker counter key address
// - every data telegram gets 32-bit signature
// - signature is aes-128 ccm with device key
// - nonce: address, counter, three zero bytes
// - nonce address and counter least byte first
// - authenticate length byte through optional data
// - append signature right after optional data
// - unique 48-bit source address identifies device
// - commissioning hands the 128-bit key over
// - private flag blocks key readback
// - commissioning-off flag stops commissioning telegrams
// - factory reset restores factory key
// - counter starts zero, steps per telegram
// - length byte follows optional data size
// ------------------------------------------------------------------
`default_nettype none
module tas_signer #(
  parameter logic [47:0] SRC_ADDR = 48'hC0FFEE123456,
  parameter logic [127:0] FACTORY_KEY = 128'h000102030405060708090A0B0C0D0E0F,
  parameter logic [15:0] MAKER_CODE = 16'h0F0F // arbitrary value
) (
  input wire logic clk, // 250 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic req_valid, // telegram request pulse
  input wire tas_pkg::tas_req_t req, // request contents
  input wire logic cfg_wr, // configuration write pulse
  input wire tas_pkg::tas_cfg_t cfg_in, // configuration flags to write
  input wire logic factory_reset, // factory reset pulse
  input wire logic key_wr, // new key write pulse
  input wire logic [127:0] key_in, // new key, byte 0 in top bits
  input wire logic key_rd, // key readback request pulse
  output logic busy, // signing in progress
  output logic tel_valid, // telegram ready pulse
  output tas_pkg::tas_tel_t tel, // telegram payload and byte count
  output logic key_rd_valid, // key readback answer pulse
  output logic [127:0] key_rd_data, // key readback data, zero if refused
  output logic key_rd_refused, // readback refused
  output tas_pkg::tas_cfg_t cfg_out, // current configuration flags
  output logic [31:0] counter // current sequence counter
);
  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? tas_pkg::TAS_AES_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h00;
    p = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        r = r ^ p;
      p = xt(p);
    end
    return r;
  endfunction

  // inverse as x^254 keeps the s-box out of a lookup table, at some area cost
  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = x;
    for (int i = 1; i < 8; i++)
    begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]}
      ^ tas_pkg::TAS_SBOX_AFFINE;
  endfunction

  function automatic logic [31:0] le32(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  function automatic logic [47:0] le48(input logic [47:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24], v[39:32], v[47:40]};
  endfunction

  function automatic logic [127:0] aes_round(input logic [127:0] s, input logic [127:0] rk,
                                             input logic last);
    logic [7:0] sb [16];
    logic [7:0] sr [16];
    logic [127:0] o;
    logic [7:0] a0;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] a3;
    for (int i = 0; i < 16; i++)
      sb[i] = sbox(s[127 - 8 * i -: 8]);
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        sr[r + 4 * c] = sb[r + 4 * ((c + r) % 4)];
    for (int c = 0; c < 4; c++)
    begin
      a0 = sr[4 * c];
      a1 = sr[4 * c + 1];
      a2 = sr[4 * c + 2];
      a3 = sr[4 * c + 3];
      if (last)
        o[127 - 32 * c -: 32] = {a0, a1, a2, a3};
      else
        o[127 - 32 * c -: 32] = {xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3, a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3,
                                 a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3, xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3)};
    end
    return o ^ rk;
  endfunction

  function automatic logic [127:0] key_next(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] t;
    logic [31:0] n0;
    logic [31:0] n1;
    logic [31:0] n2;
    t = {sbox(k[23:16]) ^ rc, sbox(k[15:8]), sbox(k[7:0]), sbox(k[31:24])};
    n0 = k[127:96] ^ t;
    n1 = k[95:64] ^ n0;
    n2 = k[63:32] ^ n1;
    return {n0, n1, n2, k[31:0] ^ n2};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tas_pkg::tas_state_t state_reg;
  tas_pkg::tas_req_t req_reg;
  tas_pkg::tas_cfg_t cfg_reg;
  tas_pkg::tas_tel_t tel_reg;
  logic [127:0] key_reg;
  logic [127:0] st_reg;
  logic [127:0] rk_reg;
  logic [7:0] rcon_reg;
  logic [3:0] round_reg;
  logic [1:0] step_reg;
  logic [31:0] s0_reg;
  logic [31:0] ctr_reg;
  logic tel_valid_reg;
  logic key_rd_valid_reg;
  logic [127:0] key_rd_data_reg;
  logic key_rd_refused_reg;

  // ----------------------------------------------------------------
  // payload and ccm block decode
  // ----------------------------------------------------------------
  wire idle = (state_reg == tas_pkg::TAS_IDLE);
  wire take = idle && req_valid;
  wire take_comm = take && req.commission && !cfg_reg.radio_commissioning_off;
  wire take_data = take && !req.commission;
  wire [103:0] nonce = {le48(SRC_ADDR), le32(ctr_reg), tas_pkg::TAS_NONCE_PAD};
  wire [127:0] blk_b0 = {tas_pkg::TAS_CCM_B0_FLAGS, nonce, tas_pkg::TAS_CCM_CTR0};
  wire [127:0] blk_a0 = {tas_pkg::TAS_CCM_A0_FLAGS, nonce, tas_pkg::TAS_CCM_CTR0};
  wire [2:0] opt_n = (req_reg.opt_size == 2'h3) ? 3'h4 : {1'b0, req_reg.opt_size};
  wire [7:0] len_code = (req_reg.opt_size == 2'h0) ? tas_pkg::TAS_LEN_OPT0 :
                        (req_reg.opt_size == 2'h1) ? tas_pkg::TAS_LEN_OPT1 :
                        (req_reg.opt_size == 2'h2) ? tas_pkg::TAS_LEN_OPT2 : tas_pkg::TAS_LEN_OPT4;
  wire [31:0] opt_mask = (req_reg.opt_size == 2'h0) ? 32'h00000000 :
                         (req_reg.opt_size == 2'h1) ? 32'hFF000000 :
                         (req_reg.opt_size == 2'h2) ? 32'hFFFF0000 : 32'hFFFFFFFF;
  wire [15:0] maker_le = {MAKER_CODE[7:0], MAKER_CODE[15:8]};
  // unused optional bytes are zero, so they double as the aad block padding
  wire [103:0] body = {len_code, tas_pkg::TAS_KIND_MFR, maker_le, le32(ctr_reg),
                       req_reg.switch_status, le32(req_reg.opt_data) & opt_mask};
  wire [7:0] aad_len = len_code - tas_pkg::TAS_LEN_TO_AAD;
  // at most 13 authenticated bytes plus the length prefix, so one aad block always does
  wire [127:0] aad = {8'h00, aad_len, body, 8'h00};
  wire [127:0] rk_nx = key_next(rk_reg, rcon_reg);
  wire [127:0] round_out = aes_round(st_reg, rk_nx, round_reg == tas_pkg::TAS_AES_ROUNDS);
  wire op_done = !idle && (round_reg == tas_pkg::TAS_AES_ROUNDS);
  wire fin = op_done && (step_reg == 2'h2);
  wire [31:0] tag = round_out[127:96] ^ s0_reg;
  wire [7:0] tag_sh = 8'(8 * (9 + 32'(opt_n)));
  wire [239:0] data_bytes = {body, 136'h0} | ({tag, 208'h0} >> tag_sh);
  wire [4:0] data_count = len_code[4:0] + tas_pkg::TAS_LEN_TO_COUNT;
  wire [239:0] comm_bytes = {tas_pkg::TAS_LEN_COMM, tas_pkg::TAS_KIND_MFR, maker_le,
                             le32(ctr_reg), key_reg, le48(SRC_ADDR)};
  wire [127:0] next_in = (step_reg == 2'h0) ? blk_b0 : round_out ^ aad;

  // ----------------------------------------------------------------
  // sequencer: s0 first, then the cbc-mac chain
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= tas_pkg::TAS_IDLE;
    else
    begin
      case (state_reg)
        tas_pkg::TAS_IDLE:
          if (take_data)
            state_reg <= tas_pkg::TAS_CRYPT;
        tas_pkg::TAS_CRYPT:
          if (fin)
            state_reg <= tas_pkg::TAS_IDLE;
        default:
          state_reg <= tas_pkg::TAS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= 128'h0;
      rk_reg <= 128'h0;
      rcon_reg <= tas_pkg::TAS_RCON_FIRST;
      round_reg <= 4'h1;
      step_reg <= 2'h0;
      s0_reg <= 32'h0;
    end
    else if (take_data || (op_done && !fin))
    begin
      st_reg <= (take_data ? blk_a0 : next_in) ^ key_reg;
      rk_reg <= key_reg;
      rcon_reg <= tas_pkg::TAS_RCON_FIRST;
      round_reg <= 4'h1;
      step_reg <= take_data ? 2'h0 : step_reg + 2'h1;
      if (op_done && (step_reg == 2'h0))
        s0_reg <= round_out[127:96];
    end
    else if (!idle)
    begin
      st_reg <= round_out;
      rk_reg <= rk_nx;
      rcon_reg <= xt(rcon_reg);
      round_reg <= round_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      req_reg <= '0;
    else if (take_data)
      req_reg <= req;
  end

  // ----------------------------------------------------------------
  // telegram release and counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tel_valid_reg <= 1'b0;
      tel_reg <= '0;
      ctr_reg <= 32'h0;
    end
    else
    begin
      tel_valid_reg <= fin || take_comm;
      if (fin)
        tel_reg <= '{count: data_count, bytes: data_bytes};
      else if (take_comm)
        tel_reg <= '{count: tas_pkg::TAS_COMM_BYTES, bytes: comm_bytes};
      if (fin || take_comm)
        ctr_reg <= ctr_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // key and configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_reg <= FACTORY_KEY;
      cfg_reg <= '0;
    end
    else if (factory_reset)
    begin
      key_reg <= FACTORY_KEY;
      cfg_reg <= '0;
    end
    else
    begin
      // a key change mid-tag would mix two keys, so a write is only taken while idle and dropped while busy
      if (key_wr && idle)
        key_reg <= key_in;
      if (cfg_wr)
        cfg_reg <= cfg_in;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_rd_valid_reg <= 1'b0;
      key_rd_data_reg <= 128'h0;
      key_rd_refused_reg <= 1'b0;
    end
    else
    begin
      key_rd_valid_reg <= key_rd;
      key_rd_refused_reg <= key_rd && cfg_reg.key_private;
      key_rd_data_reg <= (key_rd && !cfg_reg.key_private) ? key_reg : 128'h0;
    end
  end

  assign busy = !idle;
  assign tel_valid = tel_valid_reg;
  assign tel = tel_reg;
  assign key_rd_valid = key_rd_valid_reg;
  assign key_rd_data = key_rd_data_reg;
  assign key_rd_refused = key_rd_refused_reg;
  assign cfg_out = cfg_reg;
  assign counter = ctr_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_DATA_AFTER_TAG: assert property (@(posedge clk) disable iff (!arst_n)
    tel_valid_reg && (tel_reg.count != tas_pkg::TAS_COMM_BYTES) |-> $past(fin))
    else $error("data telegram released without finished tag");
  AST_DATA_LATENCY: assert property (@(posedge clk) disable iff (!arst_n)
    take_data |-> ##31 tel_valid_reg)
    else $error("signed telegram late");
  AST_CTR_STEP: assert property (@(posedge clk) disable iff (!arst_n)
    (fin || take_comm) |=> (ctr_reg == $past(ctr_reg) + 32'h1) && tel_valid_reg)
    else $error("counter did not step with telegram");
  AST_COMM_HEAD: assert property (@(posedge clk) disable iff (!arst_n)
    tel_valid_reg && (tel_reg.count == tas_pkg::TAS_COMM_BYTES)
    |-> (tel_reg.bytes[239:232] == tas_pkg::TAS_LEN_COMM) && (tel_reg.bytes[231:224] == tas_pkg::TAS_KIND_MFR))
    else $error("commissioning header wrong");
  AST_COMM_ADDR: assert property (@(posedge clk) disable iff (!arst_n)
    tel_valid_reg && (tel_reg.count == tas_pkg::TAS_COMM_BYTES) |-> tel_reg.bytes[47:0] == le48(SRC_ADDR))
    else $error("address missing from commissioning payload");
  AST_COMM_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    idle && req_valid && req.commission && cfg_reg.radio_commissioning_off |=> !tel_valid_reg)
    else $error("commissioning telegram sent while disabled");
  AST_KEY_PRIVATE: assert property (@(posedge clk) disable iff (!arst_n)
    key_rd && cfg_reg.key_private |=> key_rd_refused_reg && (key_rd_data_reg == 128'h0))
    else $error("private key returned");
  AST_FACTORY_KEY: assert property (@(posedge clk) disable iff (!arst_n)
    factory_reset |=> key_reg == FACTORY_KEY)
    else $error("factory reset left key changed");
  AST_DATA_LEN: assert property (@(posedge clk) disable iff (!arst_n)
    tel_valid_reg && (tel_reg.count != tas_pkg::TAS_COMM_BYTES)
    |-> tel_reg.count == tel_reg.bytes[236:232] + tas_pkg::TAS_LEN_TO_COUNT)
    else $error("length byte disagrees with size");
endmodule
`default_nettype wire
